// ===== design/swsq_pkg.sv
// Package with constants and types for the sweep sequencer.
//
// Contract
// - Sweep forces external modulation, rejects internal.
// - Center is mean; span is absolute difference.
// - Center/span entry keeps start/stop ordering.
// - Offer sawtooth, triangle; lin/log for frequency.
// - Ramp runs start toward stop, either direction.
// - Swap command exchanges start and stop.
// - Continuous mode repeats without triggers.
// - Triangle leg lasts one sweep time each.
// - One-shot per trigger; retrigger restarts from start.
// - One-shot ramp returns to start at end.
// - One-shot triangle holds terminated until trigger.
// - Burst-window oscillates only while sweep runs.
// - Burst-window starts/stops at configured phase; code has no phase setting, starts on the trigger and stops on halt_edge.
// - Idle level: percentage option, else stop phase; code only passes the select out on idle_pct_sel_o, idle_pct is unused.
// - Burst-window ends on full or half cycle.
// - Trigger source internal with period, or external.
// - One trigger selection serves sweep, burst, sync.
// - Manual and remote triggers accepted with either source, except in continuous or conflict.
// - External start/stop ignore trigger source selection.
// - Continuous auto-starts; stopped sweep restarts on start.
// - Conflict refuses start and triggers, flags status.
// - External stop falling edge returns to start.
// - External hold edge pauses or resumes; trigger restarts.
package swsq_pkg;
    localparam int VAL_W = 32;
    localparam int FRAC_W = 16;
    localparam logic [31:0] ADR_CTRL = 32'h0000_0000;
    localparam logic [31:0] ADR_START = 32'h0000_0004;
    localparam logic [31:0] ADR_STOP = 32'h0000_0008;
    localparam logic [31:0] ADR_TIME = 32'h0000_000C;
    localparam logic [31:0] ADR_TPER = 32'h0000_0010;
    localparam logic [31:0] ADR_CENTER = 32'h0000_0014;
    localparam logic [31:0] ADR_SPAN = 32'h0000_0018;
    localparam logic [31:0] ADR_CMD = 32'h0000_001C;
    localparam logic [31:0] ADR_STATUS = 32'h0000_0020;
    localparam logic [31:0] ADR_VALUE = 32'h0000_0024;
    localparam logic [31:0] ADR_LEVEL = 32'h0000_0028;
    localparam int CMD_START = 0;
    localparam int CMD_STOP = 1;
    localparam int CMD_HOLD = 2;
    localparam int CMD_SWAP = 3;
    localparam int CMD_MANTRIG = 4;
    localparam int CMD_REMTRIG = 5;
    localparam int CMD_CS = 6;
    localparam logic [31:0] TIME_RST = 32'h0000_0400;
    localparam logic [31:0] TPER_RST = 32'h0000_1000;
    localparam logic [31:0] BAD_DATA = 32'h0000_0000;

    typedef enum logic [1:0] {
        STY_CONT = 2'b00,
        STY_SINGLE = 2'b01,
        STY_GATED = 2'b10,
        STY_RSVD = 2'b11
    } swsq_style_t;

    typedef enum logic [2:0] {
        PAR_FREQ = 3'b000,
        PAR_PHASE = 3'b001,
        PAR_AMPTD = 3'b010,
        PAR_OFFSET = 3'b011,
        PAR_DUTY = 3'b100
    } swsq_param_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_UP = 3'b001,
        ST_DOWN = 3'b010,
        ST_HOLD = 3'b011,
        ST_TERM = 3'b100,
        ST_FINISH = 3'b101
    } swsq_state_t;

    // Control register layout, high bits first.
    typedef struct packed {
        logic [12:0] rsvd;
        logic [6:0] idle_pct;
        logic ext_ctrl_en;
        logic trig_pol;
        logic trig_ext;
        logic half_period_halt;
        logic idle_level_option;
        logic log_slope;
        logic ramp_only_function;
        swsq_param_t swept_parameter_select;
        swsq_style_t sweep_operation_style;
    } swsq_ctrl_t;

    // External control pins, active on falling edge.
    typedef struct packed {
        logic start_n;
        logic stop_n;
        logic hold_n;
    } swsq_ext_t;
endpackage

// ===== design/swsq_top.sv
// Sweep sequencer with a classic Wishbone register slave.
`timescale 1ns/100ps
`default_nettype none
module swsq_top import swsq_pkg::*; #(
    parameter int VALUE_W = VAL_W
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // External trigger and control pins
    input wire logic trig_in_i,
    input wire swsq_ext_t ext_i,
    // Oscillator interface
    input wire logic cycle_edge_i,
    input wire logic half_edge_i,
    output logic [31:0] value_o,
    output logic osc_en_o,
    output logic idle_pct_sel_o,
    output logic mod_ext_o,
    output logic sync_o,
    output logic trig_seen_o,
    output logic setting_conflict_status_o
);
    initial begin
        if (VALUE_W != VAL_W) begin
            $error("swsq_top supports only the package value width");
        end
    end

    function automatic logic [31:0] wmask(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    swsq_ctrl_t ctrl_reg;
    logic [31:0] start_reg, stop_reg, time_reg, tper_reg, center_reg, span_reg;
    logic [31:0] rdat_next;
    logic ack_reg;
    logic [2:0] trig_sync_reg;
    logic [8:0] ext_sync_reg;
    logic [31:0] tcnt_reg, pos_reg;
    logic [31:0] value_reg;
    swsq_state_t state_reg;
    logic osc_reg, sync_reg, seen_reg, started_reg;
    swsq_state_t resume_reg;

    wire req = wb_cyc_i && wb_stb_i && !ack_reg;
    wire wr = req && wb_we_i;
    wire [31:0] cmd = (wr && wb_adr_i == ADR_CMD) ? wb_dat_i : 32'h0000_0000;
    wire [31:0] ctrl_w = wmask(ctrl_reg, wb_dat_i, wb_sel_i);

    // Pin synchronisers: only stage two and three are read.
    wire trig_lvl = trig_sync_reg[1];
    wire trig_rise = trig_sync_reg[1] && !trig_sync_reg[2];
    wire trig_fall = !trig_sync_reg[1] && trig_sync_reg[2];
    wire ext_trig = ctrl_reg.trig_ext && (ctrl_reg.trig_pol ? trig_fall : trig_rise);
    wire int_trig = !ctrl_reg.trig_ext && (tcnt_reg >= tper_reg - 32'h0000_0001);
    wire [2:0] ext_now = ext_sync_reg[5:3];
    wire [2:0] ext_old = ext_sync_reg[8:6];
    wire ext_start = ctrl_reg.ext_ctrl_en && ext_old[2] && !ext_now[2];
    wire ext_stop = ctrl_reg.ext_ctrl_en && ext_old[1] && !ext_now[1];
    wire ext_hold = ctrl_reg.ext_ctrl_en && ext_old[0] && !ext_now[0];

    // Conflict covers an unusable style, zero time and log slope off frequency.
    wire conflict = ctrl_reg.sweep_operation_style == STY_RSVD || time_reg == 32'h0000_0000
        || (ctrl_reg.log_slope && ctrl_reg.swept_parameter_select != PAR_FREQ)
        || ctrl_reg.swept_parameter_select > PAR_DUTY;
    wire cont = ctrl_reg.sweep_operation_style == STY_CONT;
    wire gated = ctrl_reg.sweep_operation_style == STY_GATED;
    // One trigger path serves sweep, burst and sync.
    wire src_trig = ext_trig || int_trig;
    wire any_trig = !cont && !conflict && (src_trig || cmd[CMD_MANTRIG] || cmd[CMD_REMTRIG]
        || ext_start);
    wire do_start = !conflict && (any_trig || (cont && (cmd[CMD_START] || ext_start
        || !started_reg)));
    wire do_stop = cmd[CMD_STOP] || ext_stop;
    wire do_hold = cmd[CMD_HOLD] || ext_hold;
    wire leg_end = pos_reg >= time_reg - 32'h0000_0001;
    wire running = state_reg == ST_UP || state_reg == ST_DOWN;

    // Interpolation: fraction of sweep time in 16 fractional bits.
    wire [31:0] frac = (time_reg == 32'h0000_0000) ? 32'h0000_0000
        : 32'(({32'h0000_0000, pos_reg} << FRAC_W) / {32'h0000_0000, time_reg});
    wire [31:0] dirfrac = (state_reg == ST_DOWN) ? (32'h0001_0000 - frac) : frac;
    // Log slope approximated by squaring the fraction, which bends toward start.
    wire [31:0] shaped = ctrl_reg.log_slope
        ? 32'((64'(dirfrac) * 64'(dirfrac)) >> FRAC_W) : dirfrac;
    wire signed [32:0] diff = $signed({stop_reg[31], stop_reg})
        - $signed({start_reg[31], start_reg});
    wire signed [63:0] prod = 64'($signed(diff) * $signed({1'b0, shaped}));
    wire [31:0] interp = start_reg + 32'(prod >>> FRAC_W);

    // Center and span derived; re-entry keeps the sign of stop minus start.
    wire signed [32:0] sum = $signed({start_reg[31], start_reg})
        + $signed({stop_reg[31], stop_reg});
    wire [31:0] center_val = 32'(sum >>> 1);
    wire [31:0] span_val = diff[32] ? 32'(-diff) : 32'(diff);
    wire [31:0] half_span = {1'b0, span_reg[31:1]};
    wire [31:0] cs_lo = center_reg - half_span;
    wire [31:0] cs_hi = center_reg + half_span;

    wire halt_edge = ctrl_reg.half_period_halt ? (half_edge_i || cycle_edge_i) : cycle_edge_i;

    assign rdat_next = (wb_adr_i == ADR_CTRL) ? ctrl_reg
        : (wb_adr_i == ADR_START) ? start_reg
        : (wb_adr_i == ADR_STOP) ? stop_reg
        : (wb_adr_i == ADR_TIME) ? time_reg
        : (wb_adr_i == ADR_TPER) ? tper_reg
        : (wb_adr_i == ADR_CENTER) ? center_val
        : (wb_adr_i == ADR_SPAN) ? span_val
        : (wb_adr_i == ADR_STATUS) ? {27'h0, state_reg, osc_reg, conflict}
        : (wb_adr_i == ADR_VALUE) ? value_reg
        : BAD_DATA;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            ack_reg <= req;
            wb_dat_o <= req ? rdat_next : 32'h0000_0000;
        end
    end
    assign wb_ack_o = ack_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_reg <= '0;
            start_reg <= 32'h0000_0000;
            stop_reg <= 32'h0000_0000;
            time_reg <= TIME_RST;
            tper_reg <= TPER_RST;
            center_reg <= 32'h0000_0000;
            span_reg <= 32'h0000_0000;
        end else if (wr) begin
            if (wb_adr_i == ADR_CTRL) begin
                ctrl_reg <= swsq_ctrl_t'({13'h0, ctrl_w[18:0]});
            end
            if (wb_adr_i == ADR_START) begin
                start_reg <= wmask(start_reg, wb_dat_i, wb_sel_i);
            end
            if (wb_adr_i == ADR_STOP) begin
                stop_reg <= wmask(stop_reg, wb_dat_i, wb_sel_i);
            end
            if (wb_adr_i == ADR_TIME) begin
                time_reg <= wmask(time_reg, wb_dat_i, wb_sel_i);
            end
            if (wb_adr_i == ADR_TPER) begin
                tper_reg <= wmask(tper_reg, wb_dat_i, wb_sel_i);
            end
            if (wb_adr_i == ADR_CENTER) begin
                center_reg <= wmask(center_reg, wb_dat_i, wb_sel_i);
            end
            if (wb_adr_i == ADR_SPAN) begin
                span_reg <= wmask(span_reg, wb_dat_i, wb_sel_i);
            end
            if (wb_adr_i == ADR_CMD && wb_dat_i[CMD_SWAP]) begin
                start_reg <= stop_reg;
                stop_reg <= start_reg;
            end
            if (wb_adr_i == ADR_CMD && wb_dat_i[CMD_CS]) begin
                start_reg <= diff[32] ? cs_hi : cs_lo;
                stop_reg <= diff[32] ? cs_lo : cs_hi;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            trig_sync_reg <= 3'b000;
            ext_sync_reg <= 9'h1FF;
            tcnt_reg <= 32'h0000_0000;
        end else begin
            trig_sync_reg <= {trig_sync_reg[1:0], trig_in_i};
            ext_sync_reg <= {ext_sync_reg[5:0], ext_i};
            tcnt_reg <= int_trig ? 32'h0000_0000 : tcnt_reg + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= ST_IDLE;
            resume_reg <= ST_UP;
            pos_reg <= 32'h0000_0000;
            started_reg <= 1'b0;
            seen_reg <= 1'b0;
            osc_reg <= 1'b0;
            sync_reg <= 1'b0;
        end else begin
            seen_reg <= any_trig;
            if (!cont) begin
                started_reg <= 1'b0;
            end
            if (do_stop) begin
                state_reg <= ST_IDLE;
                pos_reg <= 32'h0000_0000;
                started_reg <= 1'b1;
                osc_reg <= 1'b0;
                sync_reg <= 1'b1;
            end else if (do_start) begin
                state_reg <= ST_UP;
                pos_reg <= 32'h0000_0000;
                started_reg <= 1'b1;
                osc_reg <= 1'b1;
                sync_reg <= 1'b0;
            end else if (do_hold && running) begin
                resume_reg <= state_reg;
                state_reg <= ST_HOLD;
            end else if (do_hold && state_reg == ST_HOLD) begin
                state_reg <= resume_reg;
            end else begin
                unique case (state_reg)
                    ST_IDLE, ST_HOLD, ST_TERM: begin
                    end
                    ST_UP: begin
                        sync_reg <= 1'b0;
                        pos_reg <= leg_end ? 32'h0000_0000 : pos_reg + 32'h0000_0001;
                        if (leg_end && !ctrl_reg.ramp_only_function) begin
                            state_reg <= ST_DOWN;
                        end else if (leg_end && cont) begin
                            sync_reg <= 1'b1;
                        end else if (leg_end) begin
                            state_reg <= gated ? ST_FINISH : ST_IDLE;
                            sync_reg <= 1'b1;
                        end
                    end
                    ST_DOWN: begin
                        pos_reg <= leg_end ? 32'h0000_0000 : pos_reg + 32'h0000_0001;
                        if (leg_end && cont) begin
                            state_reg <= ST_UP;
                            sync_reg <= 1'b0;
                        end else if (leg_end) begin
                            state_reg <= gated ? ST_FINISH : ST_TERM;
                            sync_reg <= 1'b1;
                        end
                    end
                    ST_FINISH: begin
                        if (halt_edge) begin
                            state_reg <= ctrl_reg.ramp_only_function ? ST_IDLE : ST_TERM;
                            osc_reg <= 1'b0;
                        end
                    end
                    default: begin
                        state_reg <= ST_IDLE;
                    end
                endcase
            end
            if (!gated && !do_stop) begin
                osc_reg <= 1'b1;
            end
        end
    end

    // Terminated shuttle shows the start value, where its return leg ends.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            value_reg <= 32'h0000_0000;
        end else if (state_reg == ST_TERM) begin
            value_reg <= start_reg;
        end else if (running) begin
            value_reg <= interp;
        end else if (state_reg != ST_HOLD && state_reg != ST_FINISH) begin
            value_reg <= start_reg;
        end
    end

    assign value_o = value_reg;
    assign osc_en_o = osc_reg;
    assign sync_o = sync_reg;
    assign trig_seen_o = seen_reg;
    // Registered below to keep every output a flip-flop.
    logic lvl_reg, modx_reg, cfl_reg;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lvl_reg <= 1'b0;
            modx_reg <= 1'b1;
            cfl_reg <= 1'b0;
        end else begin
            lvl_reg <= ctrl_reg.idle_level_option;
            modx_reg <= 1'b1;
            cfl_reg <= conflict;
        end
    end
    assign idle_pct_sel_o = lvl_reg;
    assign mod_ext_o = modx_reg;
    assign setting_conflict_status_o = cfl_reg;
    wire unused = trig_lvl ^ ^ctrl_reg.idle_pct ^ ^ctrl_reg.rsvd;
endmodule
`default_nettype wire

// ===== verif/swsq_chk.sv
// Checker on the ports of the sweep sequencer.
`timescale 1ns/100ps
`default_nettype none
module swsq_chk import swsq_pkg::*; (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Register bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Pins
    input wire logic trig_in_i,
    input wire swsq_ext_t ext_i,
    input wire logic cycle_edge_i,
    input wire logic half_edge_i,
    input wire logic [31:0] value_o,
    input wire logic osc_en_o,
    input wire logic idle_pct_sel_o,
    input wire logic mod_ext_o,
    input wire logic sync_o,
    input wire logic trig_seen_o,
    input wire logic setting_conflict_status_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Shadows of full-word writes; the bench never writes partial words.
    logic [31:0] ctrl_reg;
    logic [31:0] time_reg;
    wire logic wr_ctrl = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == ADR_CTRL;
    wire logic wr_time = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == ADR_TIME;
    wire logic conf_exp = ctrl_reg[1:0] == 2'h3 || time_reg == 32'h0
        || (ctrl_reg[6] && ctrl_reg[4:2] != 3'h0) || ctrl_reg[4:2] > 3'h4;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_reg <= 32'h0;
            time_reg <= TIME_RST;
        end else begin
            if (wr_ctrl) ctrl_reg <= wb_dat_i;
            if (wr_time) time_reg <= wb_dat_i;
        end
    end
    mod_ext_a: assert property (mod_ext_o)
        else $error("Modulation path left external.");
    ack_resp_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("Bus request not answered.");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("Bus answer longer than one cycle.");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("Bus answer without request.");
    trig_pulse_a: assert property (trig_seen_o |=> !trig_seen_o)
        else $error("Trigger indication longer than one cycle.");
    conflict_trig_a: assert property (setting_conflict_status_o [*3] |-> !trig_seen_o)
        else $error("Trigger accepted during conflict.");
    conflict_flag_a: assert property ($stable(conf_exp) [*4] |-> setting_conflict_status_o == conf_exp)
        else $error("Conflict flag disagrees with settings.");
    idle_sel_a: assert property ($stable(ctrl_reg[7]) [*4] |-> idle_pct_sel_o == ctrl_reg[7])
        else $error("Idle level select disagrees with control.");
    cover property (trig_seen_o);
    cover property (setting_conflict_status_o);
    cover property (wb_ack_o && !wb_we_i);
endmodule
`default_nettype wire

// ===== verif/swsq_far.sv
// Far-side model: trigger pin, external control pins, oscillator edges.
`timescale 1ns/100ps
`default_nettype none
module swsq_far import swsq_pkg::*; (
    // Clock
    input wire logic clk_i,
    // Pins toward the block
    output logic trig_o,
    output swsq_ext_t ext_o,
    output logic cycle_edge_o,
    output logic half_edge_o
);
    logic [1:0] ph_reg = 2'h0;
    initial begin
        trig_o = 1'b0;
        ext_o = 3'b111;
    end
    always_ff @(posedge clk_i) ph_reg <= ph_reg + 2'h1;
    assign cycle_edge_o = ph_reg == 2'h3;
    assign half_edge_o = ph_reg[0];
    // Held four cycles so the three-stage synchroniser cannot miss it.
    task automatic pulse_trig();
        trig_o <= 1'b1;
        repeat (4) @(posedge clk_i);
        trig_o <= 1'b0;
    endtask
    // Falling edge on one pin: 0 hold, 1 stop, 2 start.
    task automatic fall_pin(input int idx);
        ext_o[idx] <= 1'b0;
        repeat (4) @(posedge clk_i);
        ext_o[idx] <= 1'b1;
    endtask
endmodule
`default_nettype wire

// ===== verif/tb.sv
// Testbench for the sweep sequencer.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin num_errors++; \
    $display("[ERR] %0t %h %h", $time, a, b); end end
module tb import swsq_pkg::*;;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [31:0] wb_adr_i = 32'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o, value_o, q;
    logic wb_ack_o, trig_in_i, cyc_e, half_e, osc_en_o, idle_pct_sel_o;
    logic mod_ext_o, sync_o, trig_seen_o, setting_conflict_status_o;
    swsq_ext_t ext_i;
    int num_errors = 0;
    int n_checks = 0;
    int seen = 0;
    int ticks = 0;
    int base;
    always #12.5 clk_i = ~clk_i;
    swsq_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .trig_in_i(trig_in_i), .ext_i(ext_i),
        .cycle_edge_i(cyc_e), .half_edge_i(half_e), .value_o(value_o), .osc_en_o(osc_en_o),
        .idle_pct_sel_o(idle_pct_sel_o), .mod_ext_o(mod_ext_o), .sync_o(sync_o),
        .trig_seen_o(trig_seen_o), .setting_conflict_status_o(setting_conflict_status_o));
    swsq_far i_far (.clk_i(clk_i), .trig_o(trig_in_i), .ext_o(ext_i), .cycle_edge_o(cyc_e),
        .half_edge_o(half_e));
    task automatic summarize();
        if (num_errors == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    always @(posedge clk_i) begin
        if (trig_seen_o === 1'b1) seen++;
        ticks++;
        if (ticks == 3000) begin
            num_errors++;
            summarize();
        end
    end
    task automatic bus(input logic we, input logic [31:0] a, input logic [31:0] d);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rdc(input logic [31:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        `CHK(q, e)
    endtask
    task automatic trig_cmd(input int c);
        base = seen;
        bus(1'b1, ADR_CMD, 32'h1 << c);
    endtask
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        `CHK(mod_ext_o, 1'b1)
        `CHK(sync_o, 1'b0)
        bus(1'b1, ADR_TIME, 32'h8);
        bus(1'b1, ADR_START, 32'h100);
        bus(1'b1, ADR_STOP, 32'h40);
        rdc(ADR_CENTER, 32'hA0);
        rdc(ADR_SPAN, 32'hC0);
        bus(1'b1, ADR_CMD, 32'h1 << CMD_SWAP);
        rdc(ADR_START, 32'h40);
        rdc(ADR_STOP, 32'h100);
        bus(1'b1, ADR_CENTER, 32'h200);
        bus(1'b1, ADR_SPAN, 32'h80);
        bus(1'b1, ADR_CMD, 32'h1 << CMD_CS);
        rdc(ADR_START, 32'h1C0);
        rdc(ADR_STOP, 32'h240);
        rdc(32'h0000_0040, 32'h0);
        // One-shot rising ramp from a manual trigger.
        bus(1'b1, ADR_CTRL, 32'h221);
        trig_cmd(CMD_MANTRIG);
        repeat (3) @(posedge clk_i);
        `CHK(value_o > 32'h1C0, 1'b1)
        `CHK(osc_en_o, 1'b1)
        repeat (13) @(posedge clk_i);
        `CHK(value_o, 32'h1C0)
        `CHK(seen - base, 1)
        // One-shot round trip from a remote trigger.
        bus(1'b1, ADR_CTRL, 32'h281);
        trig_cmd(CMD_REMTRIG);
        repeat (9) @(posedge clk_i);
        `CHK(value_o > 32'h1C0, 1'b1)
        repeat (15) @(posedge clk_i);
        `CHK(value_o, 32'h1C0)
        `CHK(seen - base, 1)
        base = seen;
        fork
            i_far.pulse_trig();
        join_none
        repeat (30) @(posedge clk_i);
        `CHK(seen - base, 1)
        // Conflicting style refuses triggers.
        bus(1'b1, ADR_CTRL, 32'h223);
        rdc(ADR_STATUS, 32'h0000_0013);
        trig_cmd(CMD_MANTRIG);
        repeat (10) @(posedge clk_i);
        `CHK(seen - base, 0)
        // Continuous run under external start and stop pins.
        bus(1'b1, ADR_CTRL, 32'h800);
        repeat (4) @(posedge clk_i);
        `CHK(setting_conflict_status_o, 1'b0)
        `CHK(sync_o, 1'b0)
        i_far.fall_pin(1);
        repeat (2) @(posedge clk_i);
        `CHK(value_o, 32'h1C0)
        i_far.fall_pin(2);
        repeat (3) @(posedge clk_i);
        `CHK(value_o > 32'h1C0, 1'b1)
        // Gated one-shot ramp: oscillation only while the sweep runs.
        bus(1'b1, ADR_CTRL, 32'h222);
        trig_cmd(CMD_MANTRIG);
        repeat (3) @(posedge clk_i);
        `CHK(osc_en_o, 1'b1)
        repeat (20) @(posedge clk_i);
        `CHK(osc_en_o, 1'b0)
        `CHK(value_o, 32'h1C0)
        summarize();
    end
endmodule
bind swsq_top swsq_chk i_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .trig_in_i(trig_in_i),
    .ext_i(ext_i), .cycle_edge_i(cycle_edge_i), .half_edge_i(half_edge_i), .value_o(value_o),
    .osc_en_o(osc_en_o), .idle_pct_sel_o(idle_pct_sel_o), .mod_ext_o(mod_ext_o),
    .sync_o(sync_o), .trig_seen_o(trig_seen_o),
    .setting_conflict_status_o(setting_conflict_status_o));
`default_nettype wire
